/* design/oca_pkg.sv */
// Purpose: Shared constants for the overcurrent alert logic.
// Assumes: 20 MHz clock; sense samples in 10 uV steps.
// Notes: Strap codes mirror the three pin levels: float, ground, supply.
package oca_pkg;

  localparam int CLK_PERIOD_NS = 50;
  localparam int SENSE_W = 16;
  localparam int SUM_W = 24;
  localparam int SENSE_LSB_UV = 10;

  // Comparison window
  localparam int WINDOW_NS = 10000;
  localparam int WINDOW_CYC = (WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WIN_CNT_W = 8;

  // Response delay settings and the windows they need
  localparam int WINDOW_US = 10;
  localparam int DELAY_SHORT_US = 10;
  localparam int DELAY_MID_US = 50;
  localparam int DELAY_LONG_US = 100;
  localparam int DELAY_MID_EXTRA_US = 40;
  localparam int DELAY_LONG_EXTRA_US = 90;
  localparam int NEED_SHORT = DELAY_SHORT_US / WINDOW_US;
  localparam int NEED_MID = (DELAY_SHORT_US + DELAY_MID_EXTRA_US) / WINDOW_US;
  localparam int NEED_LONG =
    (DELAY_SHORT_US + DELAY_LONG_EXTRA_US) / WINDOW_US;
  localparam int CNT_W = 4;

  // Hysteresis amounts
  localparam int HYS_SMALL_UV = 2000;
  localparam int HYS_MID_UV = 4000;
  localparam int HYS_LARGE_UV = 8000;

  // Enable, disable and latch clear timing
  localparam int SLEEP_NS = 20000;
  localparam int SLEEP_CYC = SLEEP_NS / CLK_PERIOD_NS;
  localparam int WAKE_NS = 300000;
  localparam int WAKE_CYC = WAKE_NS / CLK_PERIOD_NS;
  localparam int LATCH_CLR_NS = 20000;
  localparam int LATCH_CLR_CYC =
    (LATCH_CLR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 16;

  // Strap codes
  localparam logic [1:0] STRAP_FLOAT = 2'h0;
  localparam logic [1:0] STRAP_GND = 2'h1;
  localparam logic [1:0] STRAP_SUPPLY = 2'h2;

  // APB register map (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LIMIT = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_SUM = 8'h0c;

  // CTRL fields
  localparam int CTRL_DELAY_LSB = 0;
  localparam int CTRL_HYS_LSB = 2;
  localparam logic [1:0] CTRL_DELAY_RST = 2'h0;
  localparam logic [1:0] CTRL_HYS_RST = 2'h0;
  localparam logic [15:0] LIMIT_RST = 16'hffff;

  // STATUS fields
  localparam int ST_ALERT = 0;
  localparam int ST_LOW_POWER = 1;
  localparam int ST_ACTIVE = 2;
  localparam int ST_HELD = 3;
  localparam int ST_LAST_OVER = 4;
  localparam int ST_CNT_LSB = 8;

  typedef enum {
    OCA_ACTIVE,
    OCA_SLEEPING,
    OCA_OFF,
    OCA_WAKING
  } oca_mode_e;

endpackage : oca_pkg

/* design/oca_window.sv */
// Purpose: Free-running comparison window that sums sense samples.
// Assumes: Sense samples come from logic on the same clock.
// Notes: The window never realigns, so response time varies by up to
//        one window depending on where the event lands.
`timescale 1ns/1ps
module oca_window #(
  parameter int WINDOW_CYC = oca_pkg::WINDOW_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [oca_pkg::SENSE_W-1:0] sense_in,
  output logic [oca_pkg::SUM_W-1:0] sum_out,
  output logic done_out
);

  typedef struct packed {
    logic [oca_pkg::WIN_CNT_W-1:0] pos;
    logic [oca_pkg::SUM_W-1:0] acc;
    logic [oca_pkg::SUM_W-1:0] sum;
    logic done;
  } oca_win_s;

  localparam logic [oca_pkg::WIN_CNT_W-1:0] LAST =
    oca_pkg::WIN_CNT_W'(WINDOW_CYC - 1);

  oca_win_s cur;
  oca_win_s next_cur;

  always_comb begin
    next_cur = cur;
    next_cur.done = 1'b0;
    if (cur.pos == LAST) begin
      next_cur.pos = '0;
      next_cur.sum = cur.acc + oca_pkg::SUM_W'(sense_in);
      next_cur.acc = '0;
      next_cur.done = 1'b1;
    end else begin
      next_cur.pos = cur.pos + 1'b1;
      next_cur.acc = cur.acc + oca_pkg::SUM_W'(sense_in);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign sum_out = cur.sum;
  assign done_out = cur.done;

endmodule : oca_window

/* design/oca_alert.sv */
// Purpose: Decision logic of a current-sense comparator with open-drain
//          alert, response delay, hysteresis, latch and enable control.
// Assumes: APB slave on clk_in; enable and latch pins are asynchronous.
// Notes: Flag and counter change at the end of a window; enable low clears the counter at once, the flag only when sleep ends in off.
`timescale 1ns/1ps
module oca_alert #(
  parameter int WAKE_CYC = oca_pkg::WAKE_CYC,
  parameter int SLEEP_CYC = oca_pkg::SLEEP_CYC,
  parameter int LATCH_CLR_CYC = oca_pkg::LATCH_CLR_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [oca_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [oca_pkg::SENSE_W-1:0] sense_in,
  input wire logic enable_in,
  input wire logic latch_in,
  output logic alert_out,
  output logic alert_oe_n_out
);

  typedef struct packed {
    oca_pkg::oca_mode_e mode;
    logic [oca_pkg::TMR_W-1:0] tmr;
    logic [oca_pkg::CNT_W-1:0] cnt;
    logic [oca_pkg::TMR_W-1:0] latch_lo;
    logic flag;
    logic held;
    logic last_over;
    logic en_s1;
    logic en_s2;
    logic la_s1;
    logic la_s2;
    logic [1:0] delay_sel;
    logic [1:0] hys_sel;
    logic [oca_pkg::SENSE_W-1:0] limit;
    logic [oca_pkg::SUM_W-1:0] last_sum;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic alert_oe_n;
    logic alert_data;
  } oca_state_s;

  localparam logic [oca_pkg::TMR_W-1:0] WAKE_LAST =
    oca_pkg::TMR_W'(WAKE_CYC - 1);
  localparam logic [oca_pkg::TMR_W-1:0] SLEEP_LAST =
    oca_pkg::TMR_W'(SLEEP_CYC - 1);
  localparam logic [oca_pkg::TMR_W-1:0] LATCH_CLR =
    oca_pkg::TMR_W'(LATCH_CLR_CYC);

  oca_state_s cur;
  oca_state_s next_cur;

  logic [oca_pkg::SUM_W-1:0] win_sum;
  logic win_done;

  oca_window #(
    .WINDOW_CYC(oca_pkg::WINDOW_CYC)
  ) u_window (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .sense_in(sense_in),
    .sum_out(win_sum),
    .done_out(win_done)
  );

  // Windows in a row required before the flag is raised
  function automatic logic [oca_pkg::CNT_W-1:0] need_windows(
    input logic [1:0] sel
  );
    logic [oca_pkg::CNT_W-1:0] n;
    n = oca_pkg::CNT_W'(oca_pkg::NEED_SHORT);
    if (sel == oca_pkg::STRAP_GND) begin
      n = oca_pkg::CNT_W'(oca_pkg::NEED_MID);
    end else if (sel == oca_pkg::STRAP_SUPPLY) begin
      n = oca_pkg::CNT_W'(oca_pkg::NEED_LONG);
    end
    return n;
  endfunction : need_windows

  // Hysteresis amount in sense steps; unused code acts as floating
  function automatic logic [oca_pkg::SENSE_W-1:0] hys_steps(
    input logic [1:0] sel
  );
    logic [oca_pkg::SENSE_W-1:0] h;
    h = oca_pkg::SENSE_W'(oca_pkg::HYS_SMALL_UV / oca_pkg::SENSE_LSB_UV);
    if (sel == oca_pkg::STRAP_GND) begin
      h = oca_pkg::SENSE_W'(oca_pkg::HYS_MID_UV / oca_pkg::SENSE_LSB_UV);
    end else if (sel == oca_pkg::STRAP_SUPPLY) begin
      h = oca_pkg::SENSE_W'(oca_pkg::HYS_LARGE_UV / oca_pkg::SENSE_LSB_UV);
    end
    return h;
  endfunction : hys_steps

  // Window sum compared against limit times window length, so no divider
  function automatic logic [oca_pkg::SUM_W-1:0] to_sum(
    input logic [oca_pkg::SENSE_W-1:0] level
  );
    logic [31:0] prod;
    prod = 32'(level) * 32'(oca_pkg::WINDOW_CYC);
    return prod[oca_pkg::SUM_W-1:0];
  endfunction : to_sum

  logic [oca_pkg::SUM_W-1:0] trip_sum;
  logic [oca_pkg::SUM_W-1:0] release_sum;
  logic [oca_pkg::SENSE_W-1:0] hysteresis_select;
  logic over;
  logic below;
  logic [oca_pkg::CNT_W-1:0] need;
  logic apb_access;
  logic apb_commit;

  always_comb begin
    hysteresis_select = hys_steps(cur.hys_sel);
    need = need_windows(cur.delay_sel);
    trip_sum = to_sum(cur.limit);
    // A limit under the hysteresis leaves no release level
    if (cur.limit > hysteresis_select) begin
      release_sum = to_sum(cur.limit - hysteresis_select);
    end else begin
      release_sum = '0;
    end
    over = win_sum > trip_sum;
    below = win_sum < release_sum;
    apb_access = psel_in && penable_in;
    apb_commit = apb_access && cur.pready;
  end

  always_comb begin
    next_cur = cur;

    // Pins from outside the clock domain
    next_cur.en_s1 = enable_in;
    next_cur.en_s2 = cur.en_s1;
    next_cur.la_s1 = latch_in;
    next_cur.la_s2 = cur.la_s1;

    // Latch-low time; a long enough low releases a held flag
    if (cur.la_s2) begin
      next_cur.latch_lo = '0;
    end else if (cur.latch_lo != LATCH_CLR) begin
      next_cur.latch_lo = cur.latch_lo + 1'b1;
    end
    if (cur.flag && cur.la_s2) begin
      next_cur.held = 1'b1;
    end else if (!cur.la_s2 && cur.latch_lo == LATCH_CLR) begin
      next_cur.held = 1'b0;
    end

    case (cur.mode)
      oca_pkg::OCA_ACTIVE: begin
        if (!cur.en_s2) begin
          next_cur.mode = oca_pkg::OCA_SLEEPING;
          next_cur.tmr = '0;
          next_cur.cnt = '0;
        end else if (win_done) begin
          next_cur.last_over = over;
          next_cur.last_sum = win_sum;
          if (!cur.flag) begin
            if (!over) begin
              next_cur.cnt = '0;
            end else if (cur.cnt + 1'b1 >= need) begin
              next_cur.flag = 1'b1;
              next_cur.cnt = '0;
            end else begin
              next_cur.cnt = cur.cnt + 1'b1;
            end
          end else if (below && !cur.held && !cur.la_s2) begin
            // Held flag or input still high keeps the alert low
            next_cur.flag = 1'b0;
          end
        end
      end
      oca_pkg::OCA_SLEEPING: begin
        next_cur.cnt = '0;
        if (cur.en_s2) begin
          next_cur.mode = oca_pkg::OCA_WAKING;
          next_cur.tmr = '0;
        end else if (cur.tmr == SLEEP_LAST) begin
          next_cur.mode = oca_pkg::OCA_OFF;
          next_cur.flag = 1'b0;
          next_cur.held = 1'b0;
        end else begin
          next_cur.tmr = cur.tmr + 1'b1;
        end
      end
      oca_pkg::OCA_OFF: begin
        next_cur.cnt = '0;
        next_cur.flag = 1'b0;
        next_cur.held = 1'b0;
        if (cur.en_s2) begin
          next_cur.mode = oca_pkg::OCA_WAKING;
          next_cur.tmr = '0;
        end
      end
      oca_pkg::OCA_WAKING: begin
        next_cur.cnt = '0;
        if (!cur.en_s2) begin
          next_cur.mode = oca_pkg::OCA_SLEEPING;
          next_cur.tmr = '0;
        end else if (cur.tmr == WAKE_LAST) begin
          next_cur.mode = oca_pkg::OCA_ACTIVE;
          next_cur.tmr = '0;
        end else begin
          next_cur.tmr = cur.tmr + 1'b1;
        end
      end
      default: begin
        next_cur.mode = oca_pkg::OCA_OFF;
      end
    endcase

    // Open drain: enable low pulls the wire low
    next_cur.alert_oe_n = !next_cur.flag;
    // Open-drain data stays low; only the enable ever moves
    next_cur.alert_data = 1'b0;

    // APB: one wait state so read data leaves a flip-flop
    next_cur.pready = 1'b0;
    next_cur.pslverr = 1'b0;
    if (apb_access && !cur.pready) begin
      next_cur.pready = 1'b1;
      next_cur.prdata = '0;
      if (paddr_in == oca_pkg::REG_CTRL) begin
        next_cur.prdata[oca_pkg::CTRL_DELAY_LSB +: 2] = cur.delay_sel;
        next_cur.prdata[oca_pkg::CTRL_HYS_LSB +: 2] = cur.hys_sel;
      end else if (paddr_in == oca_pkg::REG_LIMIT) begin
        next_cur.prdata[oca_pkg::SENSE_W-1:0] = cur.limit;
      end else if (paddr_in == oca_pkg::REG_STATUS) begin
        next_cur.prdata[oca_pkg::ST_ALERT] = cur.flag;
        next_cur.prdata[oca_pkg::ST_LOW_POWER] =
          cur.mode == oca_pkg::OCA_OFF;
        next_cur.prdata[oca_pkg::ST_ACTIVE] =
          cur.mode == oca_pkg::OCA_ACTIVE;
        next_cur.prdata[oca_pkg::ST_HELD] = cur.held;
        next_cur.prdata[oca_pkg::ST_LAST_OVER] = cur.last_over;
        next_cur.prdata[oca_pkg::ST_CNT_LSB +: oca_pkg::CNT_W] = cur.cnt;
      end else if (paddr_in == oca_pkg::REG_SUM) begin
        next_cur.prdata[oca_pkg::SUM_W-1:0] = cur.last_sum;
      end else begin
        next_cur.pslverr = 1'b1;
      end
    end
    // Writes land only on the edge that completes the transfer
    if (apb_commit && pwrite_in) begin
      if (paddr_in == oca_pkg::REG_CTRL) begin
        next_cur.delay_sel = pwdata_in[oca_pkg::CTRL_DELAY_LSB +: 2];
        next_cur.hys_sel = pwdata_in[oca_pkg::CTRL_HYS_LSB +: 2];
      end else if (paddr_in == oca_pkg::REG_LIMIT) begin
        next_cur.limit = pwdata_in[oca_pkg::SENSE_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cur <= '0;
      cur.mode <= oca_pkg::OCA_OFF;
      cur.delay_sel <= oca_pkg::CTRL_DELAY_RST;
      cur.hys_sel <= oca_pkg::CTRL_HYS_RST;
      cur.limit <= oca_pkg::LIMIT_RST;
      cur.alert_oe_n <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  assign prdata_out = cur.prdata;
  assign pready_out = cur.pready;
  assign pslverr_out = cur.pslverr;
  assign alert_out = cur.alert_data;
  assign alert_oe_n_out = cur.alert_oe_n;

endmodule : oca_alert

/* bench/oca_alert_chk.sv */
// Purpose: Port checker for the overcurrent alert logic.
// Assumes: Timing parameters match those of the bound instance.
// Notes: Window phase is hidden, so alert timing is checked by bounds.
`timescale 1ns/1ps
module oca_alert_chk #(
  parameter int WAKE_CYC = 20,
  parameter int SLEEP_CYC = 8,
  parameter int LATCH_CLR_CYC = 8
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic enable_in,
  input wire logic latch_in,
  input wire logic alert_out,
  input wire logic alert_oe_n_out
);
  logic [15:0] en_lo, en_hi, lat_lo, lat_hi;
  logic held_m, off_m, awake;
  function automatic logic [15:0] inc(input logic [15:0] v);
    return (v == 16'hffff) ? v : v + 16'h0001;
  endfunction : inc
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      en_lo <= 16'h0000;
      en_hi <= 16'h0000;
      lat_lo <= 16'h0000;
      lat_hi <= 16'h0000;
      held_m <= 1'b0;
      off_m <= 1'b1;
    end else begin
      en_lo <= enable_in ? 16'h0000 : inc(en_lo);
      en_hi <= enable_in ? inc(en_hi) : 16'h0000;
      lat_lo <= latch_in ? 16'h0000 : inc(lat_lo);
      lat_hi <= latch_in ? inc(lat_hi) : 16'h0000;
      held_m <= alert_oe_n_out ? 1'b0 : (lat_hi >= 16'h0003 || held_m);
      if (int'(en_lo) >= SLEEP_CYC + 6) off_m <= 1'b1;
      else if (int'(en_hi) > WAKE_CYC + 4) off_m <= 1'b0;
    end
  end
  // Only judge releases once the block has been running a while
  assign awake = int'(en_hi) > WAKE_CYC + 4 && !off_m;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_access;
    psel_in && penable_in && !pready_out;
  endsequence
  sequence s_release;
    awake && $rose(alert_oe_n_out);
  endsequence
  property p_apb_wait;
    s_access |=> pready_out;
  endproperty
  property p_apb_pulse;
    pready_out |=> !pready_out;
  endproperty
  property p_apb_err;
    pslverr_out |-> pready_out && psel_in && penable_in;
  endproperty
  property p_od_data;
    alert_out == 1'b0;
  endproperty
  property p_latch_hold;
    awake && lat_hi >= 16'h0003 && !alert_oe_n_out |=> !alert_oe_n_out;
  endproperty
  property p_release_low;
    s_release |-> lat_lo >= 16'h0002;
  endproperty
  property p_held_clear;
    s_release ##0 held_m |-> int'(lat_lo) >= LATCH_CLR_CYC;
  endproperty
  property p_sleep;
    int'(en_lo) >= SLEEP_CYC + 6 |-> alert_oe_n_out;
  endproperty
  property p_no_new;
    en_lo >= 16'h0005 && alert_oe_n_out |=> alert_oe_n_out;
  endproperty
  property p_wake;
    off_m && enable_in && int'(en_hi) <= WAKE_CYC |-> alert_oe_n_out;
  endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("ready missing after access");
  a_apb_pulse: assert property (p_apb_pulse)
    else $error("ready longer than one cycle");
  a_apb_err: assert property (p_apb_err)
    else $error("error outside completion");
  a_od_data: assert property (p_od_data)
    else $error("open drain data not low");
  a_latch_hold: assert property (p_latch_hold)
    else $error("alert left latch mode");
  a_release_low: assert property (p_release_low)
    else $error("release with latch high");
  a_held_clear: assert property (p_held_clear)
    else $error("held alert cleared too soon");
  a_sleep: assert property (p_sleep)
    else $error("alert kept in low power");
  a_no_new: assert property (p_no_new)
    else $error("new alert while disabled");
  a_wake: assert property (p_wake)
    else $error("alert during wake up");
endmodule : oca_alert_chk
bind oca_alert oca_alert_chk #(.WAKE_CYC(WAKE_CYC), .SLEEP_CYC(SLEEP_CYC),
  .LATCH_CLR_CYC(LATCH_CLR_CYC)) chk_u (.clk_in(clk_in),
  .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
  .pready_out(pready_out), .pslverr_out(pslverr_out),
  .enable_in(enable_in), .latch_in(latch_in), .alert_out(alert_out),
  .alert_oe_n_out(alert_oe_n_out));

/* bench/oca_ctrl_model.sv */
// Purpose: System controller model that watches the alert line.
// Assumes: Alert line has a pull-up.
// Notes: A clear keeps the latch pin low until the line is seen high.
`timescale 1ns/1ps
module oca_ctrl_model #(
  parameter int CLR_CYC = 8
) (
  input wire logic clk_in,
  input wire logic alert_in,
  input wire logic alert_oe_n_in,
  input wire logic arm_in,
  input wire logic clear_in,
  output logic latch_out,
  output logic line_out
);
  int hold = 0;
  assign line_out = alert_oe_n_in ? 1'b1 : alert_in;
  assign latch_out = arm_in && hold == 0;
  always @(posedge clk_in) begin
    if (clear_in) begin
      hold <= CLR_CYC + 1;
    end else if (hold > 1 || (hold == 1 && line_out)) begin
      hold <= hold - 1;
    end
  end
endmodule : oca_ctrl_model

/* bench/tb_top.sv */
// Purpose: Self-checking bench for the overcurrent alert logic.
// Assumes: Shortened wake, sleep and clear counts.
// Notes: Window phase is unknown, so alert timing uses bounds.
`timescale 1ns/1ps
module tb_top;
  localparam int W = oca_pkg::WINDOW_CYC;
  localparam int WK = 20;
  localparam int SL = 8;
  localparam int LC = 8;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e, latch, line, alert, alert_oe_n;
  logic [15:0] sense = 16'h0000;
  logic enable = 1'b1, arm = 1'b0, clear = 1'b0;
  int failures = 0;
  int checked = 0;
  int n;
  always #25 clk_in = ~clk_in;
  oca_alert #(.WAKE_CYC(WK), .SLEEP_CYC(SL), .LATCH_CLR_CYC(LC)) dut_u (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .sense_in(sense), .enable_in(enable),
    .latch_in(latch), .alert_out(alert), .alert_oe_n_out(alert_oe_n));
  oca_ctrl_model #(.CLR_CYC(LC)) ctrl_u (.clk_in(clk_in),
    .alert_in(alert), .alert_oe_n_in(alert_oe_n), .arm_in(arm),
    .clear_in(clear), .latch_out(latch), .line_out(line));
  task automatic summarize;
    if (failures == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, exp, input string m);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rq,
                     output logic re);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      chk(32'h0, 32'h1, "bus timeout");
      summarize();
    end
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_in);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q, e);
  endtask : wr
  // Waits for the line level; running out of time ends the run
  task automatic wait_line(input logic v, input int max);
    n = 0;
    while (line !== v && n <= max) begin
      @(posedge clk_in);
      n++;
    end
    chk({31'h0, n <= max}, 32'h1, "alert line wait");
    if (n > max) summarize();
  endtask : wait_line
  task automatic stay(input logic v, input int cyc);
    logic bad;
    bad = 1'b0;
    repeat (cyc) begin
      @(posedge clk_in);
      if (line !== v) bad = 1'b1;
    end
    chk({31'h0, bad}, 32'h0, "alert line moved");
  endtask : stay
  task automatic s_regs;
    apb(1'b0, oca_pkg::REG_CTRL, 32'h0, q, e);
    chk(q, 32'h0, "ctrl reset");
    apb(1'b0, oca_pkg::REG_LIMIT, 32'h0, q, e);
    chk(q, 32'h0000ffff, "limit reset");
    apb(1'b0, 8'h10, 32'h0, q, e);
    chk({31'h0, e}, 32'h1, "unmapped error");
    // Limit already includes the 50-step noise term for the 10 us delay
    wr(oca_pkg::REG_LIMIT, 32'h3e8);
  endtask : s_regs
  task automatic s_hys;
    logic [15:0] hv;
    for (int h = 0; h < 3; h++) begin
      hv = 16'h00c8 << h;
      wr(oca_pkg::REG_CTRL, 32'(h) << 2);
      sense <= 16'h044c;
      wait_line(1'b0, 2 * W + 5);
      sense <= 16'h03e8 - hv + 16'h0014;
      stay(1'b0, 3 * W);
      sense <= 16'h03e8 - hv - 16'h0014;
      wait_line(1'b1, 2 * W + 5);
    end
  endtask : s_hys
  task automatic s_delay;
    for (int d = 1; d < 3; d++) begin
      wr(oca_pkg::REG_CTRL, 32'(d));
      sense <= 16'h044c;
      wait_line(1'b0, (5 * d + 1) * W + 5);
      chk({31'h0, n > (5 * d - 1) * W}, 32'h1, "early trip");
      sense <= 16'h01f4;
      wait_line(1'b1, 2 * W + 5);
    end
    wr(oca_pkg::REG_CTRL, 32'h1);
    repeat (2) begin
      sense <= 16'h044c;
      stay(1'b1, 700);
      sense <= 16'h01f4;
      stay(1'b1, 300);
    end
  endtask : s_delay
  task automatic s_latch;
    wr(oca_pkg::REG_CTRL, 32'h0);
    arm <= 1'b1;
    sense <= 16'h044c;
    wait_line(1'b0, 2 * W + 5);
    sense <= 16'h01f4;
    stay(1'b0, 3 * W);
    sense <= 16'h044c;
    clear <= 1'b1;
    @(posedge clk_in);
    clear <= 1'b0;
    stay(1'b0, 3 * W);
    sense <= 16'h01f4;
    wait_line(1'b1, 2 * W + 5);
    repeat (2) @(posedge clk_in);
    chk({31'h0, latch}, 32'h1, "latch re-armed");
    arm <= 1'b0;
  endtask : s_latch
  task automatic s_enable;
    sense <= 16'h044c;
    wait_line(1'b0, 2 * W + 5);
    enable <= 1'b0;
    wait_line(1'b1, SL + 8);
    wr(oca_pkg::REG_CTRL, 32'h1);
    enable <= 1'b1;
    wait_line(1'b0, WK + 6 * W + 10);
    chk({31'h0, n >= WK + 4 * W}, 32'h1, "wake trip early");
    sense <= 16'h01f4;
    wait_line(1'b1, 2 * W + 5);
    sense <= 16'h044c;
    stay(1'b1, 3 * W);
    enable <= 1'b0;
    stay(1'b1, SL + 10);
    enable <= 1'b1;
    wait_line(1'b0, WK + 6 * W + 10);
    chk({31'h0, n >= WK + 4 * W}, 32'h1, "count kept");
  endtask : s_enable
  initial begin
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (WK + 10) @(posedge clk_in);
    s_regs();
    s_hys();
    s_delay();
    s_latch();
    s_enable();
    summarize();
  end
endmodule : tb_top
